// *** pkg/fpg_pkg.sv ***
// Shared types, register map, operation codes and helpers for the
// pipelined arithmetic and pixel unit.
// Assumes one clock domain and an AXI4-Lite master on the register side.
package fpg_pkg;

	// ----------------------------------------------------------------
	// Bus carriers
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

	typedef struct packed {
		logic valid;
		logic dc_n;
		logic wr_n;
		logic mio_n;
		logic [7:0] byte_enable_lines_n;
	} special_cycle_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [63:0] data;
		logic [7:0] byte_en;
	} pixel_store_t;

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_SRC1_LO = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SRC1_HI = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SRC2_LO = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_SRC2_HI = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_CMD = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_RES_LO = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_RES_HI = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_PIXEL_ACCUMULATOR_A_LO = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_PIXEL_ACCUMULATOR_A_HI = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_BASE = 8'h28;

	localparam int CMD_OP_LSB = 0;
	localparam int CMD_PS_LSB = 8;
	localparam int CMD_AUTOINC_BIT = 12;
	localparam int CMD_IMM_LSB = 16;
	localparam int STAT_CC_BIT = 0;
	localparam int STAT_PM_LSB = 8;
	localparam int STAT_PS_LSB = 16;
	localparam int XORH_SHIFT = 16;
	localparam int FRAC_BITS = 32;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [63:0] RESET_64 = 64'h0000000000000000;
	localparam logic [7:0] PM_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Pipelines, operations, pixel sizes
	// ----------------------------------------------------------------
	localparam int A_DEPTH = 3;
	localparam int M_DEPTH = 2;
	localparam int M3_DEPTH = 3;

	localparam logic [4:0] OP_EQ = 5'h00;
	localparam logic [4:0] OP_GT = 5'h01;
	localparam logic [4:0] OP_AM = 5'h02;
	localparam logic [4:0] OP_MAM = 5'h03;
	localparam logic [4:0] OP_SM = 5'h04;
	localparam logic [4:0] OP_MSM = 5'h05;
	localparam logic [4:0] OP_MUL = 5'h06;
	localparam logic [4:0] OP_MUL3 = 5'h07;
	localparam logic [4:0] OP_SUB = 5'h08;
	localparam logic [4:0] OP_TRUNC = 5'h09;
	localparam logic [4:0] OP_ZCHKL = 5'h0A;
	localparam logic [4:0] OP_ZCHKS = 5'h0B;
	localparam logic [4:0] OP_PST = 5'h0C;
	localparam logic [4:0] OP_SCYC = 5'h0D;
	localparam logic [4:0] OP_SHRA = 5'h0E;
	localparam logic [4:0] OP_XOR = 5'h0F;
	localparam logic [4:0] OP_XORH = 5'h10;
	localparam logic [4:0] OP_PADD = 5'h11;
	localparam logic [4:0] OP_FORM = 5'h12;

	localparam logic [1:0] PS_8 = 2'h0;
	localparam logic [1:0] PS_16 = 2'h1;
	localparam logic [1:0] PS_32 = 2'h2;

	localparam logic [63:0] PIXEL_ACCUMULATOR_A_MASK_8 = 64'hFF00FF00FF00FF00;
	localparam logic [63:0] PIXEL_ACCUMULATOR_A_MASK_16 = 64'hFC00FC00FC00FC00;
	localparam logic [63:0] PIXEL_ACCUMULATOR_A_MASK_32 = 64'hFF000000FF000000;
	localparam int PIXEL_ACCUMULATOR_A_SHIFT_8 = 8;
	localparam int PIXEL_ACCUMULATOR_A_SHIFT_16 = 6;

	// Byte-strobed update of a 32-bit word
	function automatic logic [31:0] apply_strobe(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r;
	endfunction : apply_strobe

endpackage : fpg_pkg

// *** verilog/zbuf_compare.sv ***
// Parallel per-field unsigned compare and minimum for depth checks.
// Purely combinational; fed from registered operands on the same clock.
`timescale 1ns/100ps
module zbuf_compare (
	input wire logic [63:0] src1,
	input wire logic [63:0] src2,
	output logic [1:0] le_wide,
	output logic [3:0] le_narrow,
	output logic [63:0] min_narrow
);
	import fpg_pkg::*;

	// --------------------------------------------------------------
	// Field compares, all fields at once
	// --------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_wide
		assign le_wide[i] = src2[32*i +: 32] <= src1[32*i +: 32];
	end

	for (genvar i = 0; i < 4; i++) begin : g_narrow
		wire [15:0] f1 = src1[16*i +: 16];
		wire [15:0] f2 = src2[16*i +: 16];
		assign le_narrow[i] = f2 <= f1;
		assign min_narrow[16*i +: 16] = (f2 <= f1) ? f2 : f1;
	end

endmodule : zbuf_compare

// *** verilog/pixel_accumulator_a_update.sv ***
// Accumulation of selected result fields into the pixel accumulator.
// Pixel size codes other than the three defined ones leave it unchanged.
`timescale 1ns/100ps
module pixel_accumulator_a_update (
	input wire logic [63:0] acc,
	input wire logic [63:0] result,
	input wire logic [1:0] pixel_size_field,
	output logic [63:0] acc_next
);
	import fpg_pkg::*;

	// --------------------------------------------------------------
	// Field selection and shift by pixel size
	// --------------------------------------------------------------
	wire [63:0] acc_8 = (acc >> PIXEL_ACCUMULATOR_A_SHIFT_8) | (result & PIXEL_ACCUMULATOR_A_MASK_8);
	wire [63:0] acc_16 = (acc >> PIXEL_ACCUMULATOR_A_SHIFT_16) | (result & PIXEL_ACCUMULATOR_A_MASK_16);
	wire [63:0] acc_32 = (acc >> PIXEL_ACCUMULATOR_A_SHIFT_8) | (result & PIXEL_ACCUMULATOR_A_MASK_32);

	assign acc_next = (pixel_size_field == PS_8) ? acc_8 :
		(pixel_size_field == PS_16) ? acc_16 :
		(pixel_size_field == PS_32) ? acc_32 : acc;

endmodule : pixel_accumulator_a_update

// *** verilog/fp_pixel_unit.sv ***
// Pipelined arithmetic, depth-check and pixel unit behind AXI4-Lite.
// Assumes a single 100 MHz clock, synchronous active-low reset and a
// master that keeps at most one write and one read outstanding.
//
// Functional notes
// - Equal compare sets flag, returns adder tail
// - Greater compare likewise, first exceeds second
// - Dual ops read operands, then advance both
// - Add-multiply variant returns multiplier tail
// - Subtract-multiply loads difference; variant returns multiplier tail
// - Multiply advances only multiplier pipeline
// - Three-stage multiply returns and advances own pipe
// - Subtract advances adder with difference
// - Truncation enters integer part, returns adder tail
// - Wide depth check: mask shift two, bits 6-7
// - Narrow depth check: mask shift four, bits 4-7
// - Narrow check returns graphics tail, stores minimum
// - Pixel store masked by pixel mask, shifts mask; 8-bit pixel size clears it
// - Special cycle drives fixed indications, byte enables
// - Arithmetic right shift replicates sign
// - High XOR uses shifted immediate; flag on zero
// - Pixel add accumulates fields by pixel size
`timescale 1ns/100ps
module fp_pixel_unit (
	input wire logic aclk,
	input wire logic aresetn,
	input wire fpg_pkg::axil_req_t axil_req,
	output fpg_pkg::axil_rsp_t axil_rsp,
	output fpg_pkg::special_cycle_t scyc_out,
	output fpg_pkg::pixel_store_t pst_out
);
	import fpg_pkg::*;

	typedef enum logic [1:0] {W_COLLECT = 2'b01, W_RESP = 2'b10} wr_state_t;
	typedef enum logic [1:0] {R_IDLE = 2'b01, R_DATA = 2'b10} rd_state_t;

	// --------------------------------------------------------------
	// Register bus slave
	// --------------------------------------------------------------
	wr_state_t wr_state_reg;
	rd_state_t rd_state_reg;
	logic aw_full_reg, w_full_reg, awready_reg, wready_reg;
	logic arready_reg, go_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;

	wire aw_take = axil_req.awvalid && awready_reg;
	wire w_take = axil_req.wvalid && wready_reg;
	wire do_write = aw_full_reg && w_full_reg && (wr_state_reg == W_COLLECT);
	wire aw_full_next = !do_write && (aw_full_reg || aw_take);
	wire w_full_next = !do_write && (w_full_reg || w_take);
	wire ar_take = axil_req.arvalid && arready_reg;
	wire wr_known = awaddr_reg <= OFF_BASE && awaddr_reg[1:0] == 2'h0;
	wire rd_known = axil_req.araddr <= OFF_BASE
		&& axil_req.araddr[1:0] == 2'h0;
	wire wr_cmd = do_write && awaddr_reg == OFF_CMD;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			wr_state_reg <= W_COLLECT;
			bresp_reg <= RESP_OKAY;
			go_reg <= 1'b0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awready_reg <= !aw_full_next;
			wready_reg <= !w_full_next;
			go_reg <= wr_cmd;
			if (aw_take) begin
				awaddr_reg <= axil_req.awaddr;
			end
			if (w_take) begin
				wdata_reg <= axil_req.wdata;
				wstrb_reg <= axil_req.wstrb;
			end
			case (wr_state_reg)
				W_COLLECT: if (do_write) begin
					wr_state_reg <= W_RESP;
					bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
				end
				W_RESP: if (axil_req.bready) begin
					wr_state_reg <= W_COLLECT;
				end
				default: wr_state_reg <= W_COLLECT;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Architectural state
	// --------------------------------------------------------------
	logic [63:0] src1_reg, src2_reg, res_reg, pixel_accumulator_a_reg, gfx_reg;
	logic [63:0] a_pipe_reg [A_DEPTH];
	logic [63:0] m_pipe_reg [M_DEPTH];
	logic [63:0] m3_pipe_reg [M3_DEPTH];
	logic [31:0] cmd_reg, base_reg;
	logic [7:0] pm_reg;
	logic cc_reg;
	special_cycle_t scyc_reg;
	pixel_store_t pst_reg;

	wire [4:0] op = cmd_reg[CMD_OP_LSB +: 5];
	wire [1:0] pixel_size_field = cmd_reg[CMD_PS_LSB +: 2];
	wire [15:0] imm = cmd_reg[CMD_IMM_LSB +: 16];

	// Q32.32 fixed-point datapath stands in for the float formats
	wire [63:0] a_sum = src1_reg + src2_reg;
	wire [63:0] a_diff = src1_reg - src2_reg;
	wire signed [127:0] m_full = $signed(src1_reg) * $signed(src2_reg);
	wire [63:0] m_prod = m_full[FRAC_BITS +: 64];
	wire neg_frac = src1_reg[63] && (src1_reg[FRAC_BITS-1:0] != 32'h0);
	wire [31:0] int_part = src1_reg[63:FRAC_BITS] + {31'h0, neg_frac};
	wire [63:0] a_trunc = {int_part, 32'h0};
	wire [31:0] sh_res = $signed(src2_reg[31:0]) >>> src1_reg[4:0];
	wire [31:0] xor_res = src1_reg[31:0] ^ src2_reg[31:0];
	wire [31:0] xorh_res = {imm, 16'h0} ^ src2_reg[31:0];
	wire [31:0] pst_addr = base_reg + {{16{imm[15]}}, imm};
	wire [1:0] le_wide;
	wire [3:0] le_narrow;
	wire [63:0] min_narrow, pixel_accumulator_a_next;

	zbuf_compare u_zbuf (
		.src1(src1_reg),
		.src2(src2_reg),
		.le_wide(le_wide),
		.le_narrow(le_narrow),
		.min_narrow(min_narrow)
	);

	pixel_accumulator_a_update u_pixel_accumulator_a (
		.acc(pixel_accumulator_a_reg),
		.result(a_sum),
		.pixel_size_field(pixel_size_field),
		.acc_next(pixel_accumulator_a_next)
	);

	// --------------------------------------------------------------
	// Operation decode
	// --------------------------------------------------------------
	wire op_cmp = op == OP_EQ || op == OP_GT;
	wire op_dual = op == OP_AM || op == OP_MAM || op == OP_SM
		|| op == OP_MSM;
	wire a_adv = go_reg && (op_cmp || op_dual || op == OP_SUB
		|| op == OP_TRUNC || op == OP_PADD);
	wire m_adv = go_reg && (op_dual || op == OP_MUL);
	wire m3_adv = go_reg && op == OP_MUL3;
	wire a_sub = op == OP_SM || op == OP_MSM || op == OP_SUB;
	// Compares leave the first stage undefined; zero is loaded
	wire [63:0] a_new = op_cmp ? RESET_64 :
		a_sub ? a_diff :
		(op == OP_TRUNC) ? a_trunc : a_sum;
	wire [63:0] a_tail = a_pipe_reg[A_DEPTH-1];
	wire [63:0] m_tail = m_pipe_reg[M_DEPTH-1];
	wire [63:0] m3_tail = m3_pipe_reg[M3_DEPTH-1];
	wire ret_m = op == OP_MAM || op == OP_MSM || op == OP_MUL;
	wire ret_gfx = op == OP_ZCHKL || op == OP_ZCHKS || op == OP_FORM;

	logic [63:0] res_next;
	always_comb begin
		res_next = res_reg;
		if (ret_m) begin
			res_next = m_tail;
		end else if (op == OP_MUL3) begin
			res_next = m3_tail;
		end else if (a_adv) begin
			res_next = a_tail;
		end else if (ret_gfx) begin
			res_next = gfx_reg;
		end else if (op == OP_SHRA) begin
			res_next = {32'h0, sh_res};
		end else if (op == OP_XOR) begin
			res_next = {32'h0, xor_res};
		end else if (op == OP_XORH) begin
			res_next = {32'h0, xorh_res};
		end
	end

	logic [7:0] pm_next;
	logic [7:0] pst_be;
	always_comb begin
		pm_next = pm_reg;
		pst_be = pm_reg;
		case (op)
			OP_ZCHKL: pm_next = {le_wide, pm_reg[7:2]};
			OP_ZCHKS: pm_next = {le_narrow, pm_reg[7:4]};
			OP_PST: begin
				case (pixel_size_field)
					PS_16: begin
						pst_be = {{2{pm_reg[3]}}, {2{pm_reg[2]}},
							{2{pm_reg[1]}}, {2{pm_reg[0]}}};
						pm_next = {4'h0, pm_reg[7:4]};
					end
					PS_32: begin
						pst_be = {{4{pm_reg[1]}}, {4{pm_reg[0]}}};
						pm_next = {2'h0, pm_reg[7:2]};
					end
					default: pm_next = 8'h00;
				endcase
			end
			default: pm_next = pm_reg;
		endcase
	end

	// --------------------------------------------------------------
	// State update: one command, one cycle
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src1_reg <= RESET_64;
			src2_reg <= RESET_64;
			cmd_reg <= 32'h0;
			base_reg <= 32'h0;
		end else if (do_write) begin
			case (awaddr_reg)
				OFF_SRC1_LO: src1_reg[31:0] <= apply_strobe(src1_reg[31:0],
					wdata_reg, wstrb_reg);
				OFF_SRC1_HI: src1_reg[63:32] <= apply_strobe(
					src1_reg[63:32], wdata_reg, wstrb_reg);
				OFF_SRC2_LO: src2_reg[31:0] <= apply_strobe(src2_reg[31:0],
					wdata_reg, wstrb_reg);
				OFF_SRC2_HI: src2_reg[63:32] <= apply_strobe(
					src2_reg[63:32], wdata_reg, wstrb_reg);
				OFF_CMD: cmd_reg <= apply_strobe(cmd_reg, wdata_reg,
					wstrb_reg);
				OFF_BASE: base_reg <= apply_strobe(base_reg, wdata_reg,
					wstrb_reg);
				default: cmd_reg <= cmd_reg;
			endcase
		end else if (go_reg && op == OP_PST && cmd_reg[CMD_AUTOINC_BIT]) begin
			base_reg <= pst_addr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < A_DEPTH; i++) a_pipe_reg[i] <= RESET_64;
			for (int i = 0; i < M_DEPTH; i++) m_pipe_reg[i] <= RESET_64;
			for (int i = 0; i < M3_DEPTH; i++) m3_pipe_reg[i] <= RESET_64;
		end else begin
			// Shift and load in the same edge, so the tail read above
			// is the value from before the advance
			if (a_adv) begin
				for (int i = A_DEPTH-1; i > 0; i--)
					a_pipe_reg[i] <= a_pipe_reg[i-1];
				a_pipe_reg[0] <= a_new;
			end
			if (m_adv) begin
				for (int i = M_DEPTH-1; i > 0; i--)
					m_pipe_reg[i] <= m_pipe_reg[i-1];
				m_pipe_reg[0] <= m_prod;
			end
			if (m3_adv) begin
				for (int i = M3_DEPTH-1; i > 0; i--)
					m3_pipe_reg[i] <= m3_pipe_reg[i-1];
				m3_pipe_reg[0] <= m_prod;
			end
		end
	end

	wire clr_pixel_accumulator_a = op == OP_ZCHKL || op == OP_ZCHKS || op == OP_FORM;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_reg <= RESET_64;
			pixel_accumulator_a_reg <= RESET_64;
			gfx_reg <= RESET_64;
			pm_reg <= PM_RESET;
			cc_reg <= 1'b0;
		end else if (go_reg) begin
			res_reg <= res_next;
			pm_reg <= pm_next;
			if (clr_pixel_accumulator_a) begin
				pixel_accumulator_a_reg <= RESET_64;
			end else if (op == OP_PADD) begin
				pixel_accumulator_a_reg <= pixel_accumulator_a_next;
			end
			if (op == OP_ZCHKS) begin
				gfx_reg <= min_narrow;
			end else if (op == OP_FORM) begin
				gfx_reg <= src1_reg | pixel_accumulator_a_reg;
			end
			if (op == OP_EQ) begin
				cc_reg <= src1_reg == src2_reg;
			end else if (op == OP_GT) begin
				cc_reg <= $signed(src1_reg) > $signed(src2_reg);
			end else if (op == OP_XOR) begin
				cc_reg <= xor_res == 32'h0;
			end else if (op == OP_XORH) begin
				cc_reg <= xorh_res == 32'h0;
			end
		end
	end

	// --------------------------------------------------------------
	// External cycles and read data
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scyc_reg <= '{valid: 1'b0, dc_n: 1'b1, wr_n: 1'b0, mio_n: 1'b1,
				byte_enable_lines_n: 8'hFF};
			pst_reg <= '0;
		end else begin
			scyc_reg.valid <= go_reg && op == OP_SCYC;
			pst_reg.valid <= go_reg && op == OP_PST;
			if (go_reg && op == OP_SCYC) begin
				scyc_reg.dc_n <= 1'b0;
				scyc_reg.wr_n <= 1'b1;
				scyc_reg.mio_n <= 1'b0;
				scyc_reg.byte_enable_lines_n <= src2_reg[7:0];
			end
			if (go_reg && op == OP_PST) begin
				pst_reg.addr <= pst_addr;
				pst_reg.data <= src1_reg;
				pst_reg.byte_en <= pst_be;
			end
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		case (axil_req.araddr)
			OFF_SRC1_LO: rd_mux = src1_reg[31:0];
			OFF_SRC1_HI: rd_mux = src1_reg[63:32];
			OFF_SRC2_LO: rd_mux = src2_reg[31:0];
			OFF_SRC2_HI: rd_mux = src2_reg[63:32];
			OFF_CMD: rd_mux = cmd_reg;
			OFF_RES_LO: rd_mux = res_reg[31:0];
			OFF_RES_HI: rd_mux = res_reg[63:32];
			OFF_STATUS: rd_mux = {14'h0, pixel_size_field, pm_reg, 7'h0,
				cc_reg};
			OFF_PIXEL_ACCUMULATOR_A_LO: rd_mux = pixel_accumulator_a_reg[31:0];
			OFF_PIXEL_ACCUMULATOR_A_HI: rd_mux = pixel_accumulator_a_reg[63:32];
			OFF_BASE: rd_mux = base_reg;
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_reg <= R_IDLE;
			arready_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= RESP_OKAY;
		end else begin
			case (rd_state_reg)
				R_IDLE: begin
					arready_reg <= !ar_take;
					if (ar_take) begin
						rd_state_reg <= R_DATA;
						rdata_reg <= rd_mux;
						rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
					end
				end
				R_DATA: if (axil_req.rready) begin
					rd_state_reg <= R_IDLE;
					arready_reg <= 1'b1;
				end
				default: rd_state_reg <= R_IDLE;
			endcase
		end
	end

	// Valid flags are the one-hot response bits, straight from flip-flops
	assign axil_rsp = '{awready: awready_reg, wready: wready_reg,
		bvalid: wr_state_reg[1], bresp: bresp_reg,
		arready: arready_reg, rvalid: rd_state_reg[1],
		rdata: rdata_reg, rresp: rresp_reg};
	assign scyc_out = scyc_reg;
	assign pst_out = pst_reg;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	sequence s_issue(logic [4:0] code);
		go_reg && op == code;
	endsequence

	property p_eq_flag;
		@(posedge aclk) disable iff (!aresetn)
		s_issue(OP_EQ) |=> cc_reg == ($past(src1_reg) == $past(src2_reg))
			&& res_reg == $past(a_tail);
	endproperty
	a_eq_flag: assert property (p_eq_flag) else $error("eq compare wrong");

	property p_gt_flag;
		@(posedge aclk) disable iff (!aresetn)
		s_issue(OP_GT) |=> cc_reg == ($signed($past(src1_reg))
			> $signed($past(src2_reg)));
	endproperty
	a_gt_flag: assert property (p_gt_flag) else $error("gt compare wrong");

	property p_dual_adv;
		@(posedge aclk) disable iff (!aresetn)
		s_issue(OP_MAM) |=> res_reg == $past(m_tail)
			&& m_pipe_reg[0] == $past(m_prod) && a_pipe_reg[0] == $past(a_sum)
			&& a_pipe_reg[1] == $past(a_pipe_reg[0]);
	endproperty
	a_dual_adv: assert property (p_dual_adv) else $error("dual op wrong");

	property p_mul_only;
		@(posedge aclk) disable iff (!aresetn)
		s_issue(OP_MUL) |=> $stable(a_pipe_reg[0])
			&& m_pipe_reg[0] == $past(m_prod);
	endproperty
	a_mul_only: assert property (p_mul_only) else $error("mul advance wrong");

	property p_zchkl;
		@(posedge aclk) disable iff (!aresetn)
		s_issue(OP_ZCHKL) |=> pm_reg[5:0] == $past(pm_reg[7:2])
			&& pixel_accumulator_a_reg == RESET_64 && res_reg == $past(gfx_reg);
	endproperty
	a_zchkl: assert property (p_zchkl) else $error("wide depth check wrong");

	property p_zchks;
		@(posedge aclk) disable iff (!aresetn)
		s_issue(OP_ZCHKS) |=> pm_reg[3:0] == $past(pm_reg[7:4])
			&& gfx_reg == $past(min_narrow) && res_reg == $past(gfx_reg);
	endproperty
	a_zchks: assert property (p_zchks) else $error("narrow check wrong");

	sequence s_store_pulse;
		pst_out.valid ##1 !pst_out.valid;
	endsequence
	property p_pst;
		@(posedge aclk) disable iff (!aresetn)
		s_issue(OP_PST) |=> s_store_pulse;
	endproperty
	a_pst: assert property (p_pst) else $error("pixel store pulse wrong");

	property p_scyc;
		@(posedge aclk) disable iff (!aresetn)
		s_issue(OP_SCYC) |=> scyc_out.valid && !scyc_out.dc_n
			&& scyc_out.wr_n && !scyc_out.mio_n
			&& scyc_out.byte_enable_lines_n == $past(src2_reg[7:0]);
	endproperty
	a_scyc: assert property (p_scyc) else $error("special cycle wrong");

	property p_xorh;
		@(posedge aclk) disable iff (!aresetn)
		s_issue(OP_XORH) |=> res_reg[31:0] == ({$past(imm), 16'h0}
			^ $past(src2_reg[31:0])) && cc_reg == (res_reg[31:0] == 32'h0);
	endproperty
	a_xorh: assert property (p_xorh) else $error("high xor wrong");

endmodule : fp_pixel_unit

// *** verification/issue_master.sv ***
// Register-bus master standing in for the issue logic.
// Assumes one clock; the bench timeout bounds every wait.
`timescale 1ns/100ps
module issue_master (
	input wire logic aclk,
	output fpg_pkg::axil_req_t req,
	input wire fpg_pkg::axil_rsp_t rsp
);
	import fpg_pkg::*;
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		r = rsp.bresp;
		req.bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd
endmodule : issue_master

// *** verification/tb_top.sv ***
// Self-checking bench for the pipelined arithmetic and pixel unit.
// Assumes issue_master drives the register bus.
`timescale 1ns/100ps
module tb_top;
	import fpg_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	axil_req_t axil_req;
	axil_rsp_t axil_rsp;
	special_cycle_t scyc_out;
	pixel_store_t pst_out;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed = 2;
	logic [63:0] a, b, res, m;
	logic [31:0] st, ml, mh;
	logic [63:0] pulses = 64'h0;
	logic [7:0] pm;
	logic [3:0] z;
	logic [1:0] r;
	always #5 aclk = ~aclk;
	fp_pixel_unit i_fp_pixel_unit (.aclk(aclk), .aresetn(aresetn),
		.axil_req(axil_req), .axil_rsp(axil_rsp), .scyc_out(scyc_out),
		.pst_out(pst_out));
	issue_master i_issue_master (.aclk(aclk), .req(axil_req),
		.rsp(axil_rsp));
	task automatic chk(input string n, input logic [63:0] e, g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	// Fields compare unsigned, second operand against first
	function automatic logic [3:0] zle(input logic [63:0] x, y, int w);
		zle = 4'h0;
		for (int i = 0; i < 64 / w; i++)
			zle[i] = ((y >> w * i) & ((64'h1 << w) - 1)) <=
				((x >> w * i) & ((64'h1 << w) - 1));
	endfunction : zle
	function automatic logic [63:0] zmin(input logic [63:0] x, y);
		for (int i = 0; i < 4; i++)
			zmin[16*i +: 16] = (y[16*i +: 16] <= x[16*i +: 16]) ?
				y[16*i +: 16] : x[16*i +: 16];
	endfunction : zmin
	task automatic op(input logic [31:0] c, input logic [63:0] x, y);
		logic [31:0] lo, hi;
		i_issue_master.wr(OFF_SRC1_LO, x[31:0], r);
		i_issue_master.wr(OFF_SRC1_HI, x[63:32], r);
		i_issue_master.wr(OFF_SRC2_LO, y[31:0], r);
		i_issue_master.wr(OFF_SRC2_HI, y[63:32], r);
		i_issue_master.wr(OFF_CMD, c, r);
		repeat (2) @(posedge aclk);
		i_issue_master.rd(OFF_RES_LO, lo, r);
		i_issue_master.rd(OFF_RES_HI, hi, r);
		i_issue_master.rd(OFF_STATUS, st, r);
		res = {hi, lo};
	endtask : op
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (pst_out.valid || scyc_out.valid) pulses <= pulses + 64'h1;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		i_issue_master.rd(OFF_STATUS, st, r);
		chk("status", 64'h0, {32'h0, st});
		i_issue_master.rd(8'h2C, st, r);
		chk("rresp", {62'h0, RESP_SLVERR}, {62'h0, r});
		i_issue_master.wr(8'h2C, 32'h0, r);
		chk("bresp", {62'h0, RESP_SLVERR}, {62'h0, r});
		for (int i = 0; i < 8; i++) begin
			a = {$random(seed), $random(seed)};
			b = (i == 0) ? a : {$random(seed), $random(seed)};
			op({27'h0, OP_XOR}, a, b);
			chk("xor", {32'h0, a[31:0] ^ b[31:0]}, res);
			chk("xor cc", {63'h0, a[31:0] == b[31:0]}, {63'h0, st[0]});
			op({a[15:0], 11'h0, OP_XORH}, a, b);
			chk("xorh", {32'h0, b[31:0] ^ {a[15:0], 16'h0}}, res);
			op({27'h0, OP_SHRA}, {59'h0, a[4:0]}, b);
			chk("shra", {32'h0, $signed(b[31:0]) >>> a[4:0]}, res);
		end
		$display("logic ops done");
		op({27'h0, OP_SUB}, a, b);
		op({27'h0, OP_EQ}, a, a);
		chk("eq cc", 64'h1, {63'h0, st[0]});
		op({27'h0, OP_GT}, 64'h2, 64'h1);
		chk("gt cc", 64'h1, {63'h0, st[0]});
		op({27'h0, OP_GT}, 64'h1, 64'h2);
		chk("gt cc", 64'h0, {63'h0, st[0]});
		chk("adder tail", a - b, res);
		for (int i = 0; i < 4; i++)
			op({27'h0, OP_MUL3}, (i == 0) ? 64'h0000000200000000 : 64'h0,
				(i == 0) ? 64'h0000000300000000 : 64'h0);
		chk("mul3 tail", 64'h0000000600000000, res);
		// Both pipes start empty here; 5.0 and 2.0 give 7, 3 and 10
		op({27'h0, OP_AM}, 64'h0000000500000000, 64'h0000000200000000);
		op({27'h0, OP_MUL}, 64'h0000000200000000, 64'h0000000200000000);
		op({27'h0, OP_MAM}, 64'h0000000500000000, 64'h0000000200000000);
		chk("mam tail", 64'h0000000A00000000, res);
		op({27'h0, OP_TRUNC}, 64'hFFFFFFFD80000000, 64'h0);
		op({27'h0, OP_MSM}, 64'h0000000500000000, 64'h0000000200000000);
		chk("mul tail", 64'h0000000400000000, res);
		op({27'h0, OP_SM}, 64'h0000000500000000, 64'h0000000200000000);
		chk("dual sum", 64'h0000000700000000, res);
		op({22'h0, PS_8, 3'h0, OP_PADD}, 64'h1122334455667788, 64'h0);
		chk("trunc", 64'hFFFFFFFE00000000, res);
		op({22'h0, PS_16, 3'h0, OP_PADD}, 64'hFFFFFFFFFFFFFFFF, 64'h0);
		chk("dual diff", 64'h0000000300000000, res);
		m = ((64'h1122334455667788 & PIXEL_ACCUMULATOR_A_MASK_8) >> 6) | PIXEL_ACCUMULATOR_A_MASK_16;
		i_issue_master.rd(OFF_PIXEL_ACCUMULATOR_A_LO, ml, r);
		i_issue_master.rd(OFF_PIXEL_ACCUMULATOR_A_HI, mh, r);
		chk("pixel_accumulator_a", m, {mh, ml});
		op({27'h0, OP_FORM}, 64'h00000000000000F0, 64'h0);
		m = m | 64'h00000000000000F0;
		$display("pipelines done");
		pm = 8'h00;
		op({27'h0, OP_ZCHKS}, a, b);
		chk("form", m, res);
		pm = {zle(a, b, 16), pm[7:4]};
		m = zmin(a, b);
		op({27'h0, OP_ZCHKS}, b, a);
		pm = {zle(b, a, 16), pm[7:4]};
		chk("zchk16 tail", m, res);
		chk("zchk16 mask", {56'h0, pm}, {56'h0, st[15:8]});
		op({27'h0, OP_ZCHKL}, a, b);
		z = zle(a, b, 32);
		pm = {z[1:0], pm[7:2]};
		chk("zchk32 mask", {56'h0, pm}, {56'h0, st[15:8]});
		op({27'h0, OP_SCYC}, a, b);
		chk("scyc", {53'h0, 3'b010, b[7:0]}, {53'h0, scyc_out.dc_n,
			scyc_out.wr_n, scyc_out.mio_n, scyc_out.byte_enable_lines_n});
		i_issue_master.wr(OFF_BASE, a[31:0], r);
		chk("bresp", {62'h0, RESP_OKAY}, {62'h0, r});
		op({16'h0010, 3'h0, 1'b1, 2'h0, PS_8, 3'h0, OP_PST}, a, b);
		chk("pst be", {56'h0, pm}, {56'h0, pst_out.byte_en});
		chk("pst addr", {32'h0, a[31:0] + 32'h10},
			{32'h0, pst_out.addr});
		chk("pst data", a, pst_out.data);
		chk("pst mask", 64'h0, {56'h0, st[15:8]});
		i_issue_master.rd(OFF_BASE, st, r);
		chk("base", {32'h0, a[31:0] + 32'h10}, {32'h0, st});
		chk("pulses", 64'h2, pulses);
		$display("pixel ops done");
		conclude();
	end
endmodule : tb_top
